// ==== verilog/sdwp_cmd_unit.sv ====
// Card side command unit for write register, erase and protect commands
`timescale 1ns/1ps

module sdwp_cmd_unit
   import sdwp_pkg::*;
#(
   parameter int WP_GROUPS = 64
)(
   input  wire logic        mclk,
   input  wire logic        rst,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        high_cap,
   input  wire logic        mmc_mode,
   input  wire logic        cmd_valid,
   input  wire logic [5:0]  cmd_index,
   input  wire logic [31:0] cmd_arg,
   input  wire logic        blk_valid,
   input  wire logic [31:0] blk_word,
   input  wire logic        blk_last,
   input  wire logic        erase_ack,
   output logic             resp_valid,
   output logic             resp_busy_type,
   output logic             resp_illegal,
   output logic             resp_blk_len_err,
   output logic             resp_erase_seq_err,
   output logic             erase_req,
   output logic      [31:0] erase_first,
   output logic      [31:0] erase_last,
   output logic             erase_groups,
   output logic             wp_tx_valid,
   output logic      [31:0] wp_tx_word,
   output logic             wr_multi_active,
   output logic             dat0_out,
   output logic             dat0_oe
);

   if (WP_GROUPS < 1 || WP_GROUPS > 65536)
      $error("WP_GROUPS out of range");

   sdwp_wp_if #(.GROUPS(WP_GROUPS)) wp_bus ();

   sdwp_wp_map #(.GROUPS(WP_GROUPS)) u_map (
      .mclk (mclk),
      .rst  (rst),
      .wp   (wp_bus.map)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Declarations

   sdwp_state_t  state_reg;
   logic [31:0]  ctrl_reg;
   logic [31:0]  blk_len_reg;
   logic [31:0]  er_start_reg;
   logic [31:0]  er_end_reg;
   logic         er_start_ok_reg;
   logic         er_end_ok_reg;
   logic         id_done_reg;
   logic [31:0]  id_reg [4];
   logic [31:0]  spec_reg [4];
   logic [1:0]   word_cnt_reg;
   logic [7:0]   busy_cnt_reg;
   logic         set_bit_reg;
   logic         clr_bit_reg;
   logic [31:0]  grp_idx_reg;
   logic         last_illegal_reg;
   logic         blk_len_err_reg;
   logic         apb_access;
   logic [31:0]  rd_next;
   logic         rd_hit;
   logic         is_wp_cmd;
   logic         cmd_take;
   logic         erase_go;

   // Data address to bytes per capacity class
   function automatic logic [31:0] to_bytes(input logic [31:0] a, input logic hc);
      return hc ? {a[31-BLOCK_SHIFT:0], BLOCK_SHIFT'(0)} : a;
   endfunction

   // Protection group holding a byte address
   function automatic logic [31:0] grp_of(input logic [31:0] a, input logic [3:0] gsh);
      return a >> (BLOCK_SHIFT + 32'(gsh));
   endfunction

   // Programmable bits only take new data
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [1:0] w);
      logic [31:0] m;
      m = SPEC_PMASK[32*(3-w) +: 32];
      return (old & ~m) | (nw & m);
   endfunction

   assign is_wp_cmd = (cmd_index == CMD_WP_SET) || (cmd_index == CMD_WP_CLR)
                    || (cmd_index == CMD_WP_QUERY);
   assign cmd_take  = cmd_valid && (state_reg == SDWP_IDLE);
   assign erase_go  = cmd_take && (cmd_index == CMD_ERASE) && er_start_ok_reg && er_end_ok_reg;

   assign wp_bus.set_bit = set_bit_reg;
   assign wp_bus.clr_bit = clr_bit_reg;
   assign wp_bus.grp_idx = grp_idx_reg;
   assign wp_bus.rd_base = grp_idx_reg;

   ////////////////////////////////////////////////////////////////////////////////
   // Command decode and sequencing

   // Main state machine
   always_ff @(posedge mclk)
   begin
      if (rst)
         state_reg <= SDWP_IDLE;
      else
      begin
         case (state_reg)
            SDWP_IDLE:
            begin
               if (cmd_valid)
               begin
                  if (cmd_index == CMD_PROG_ID && !id_done_reg)
                     state_reg <= SDWP_RX_ID;
                  else if (cmd_index == CMD_PROG_SPEC)
                     state_reg <= SDWP_RX_SPEC;
                  else if (erase_go)
                     state_reg <= SDWP_ERASE;
                  else if (is_wp_cmd && !high_cap && ctrl_reg[CTRL_WP_FEAT])
                     state_reg <= (cmd_index == CMD_WP_QUERY) ? SDWP_WP_SEND : SDWP_WP_BUSY;
               end
            end
            SDWP_RX_ID, SDWP_RX_SPEC:
               if (blk_valid && blk_last)
                  state_reg <= SDWP_IDLE;
            SDWP_ERASE:
               if (erase_ack)
                  state_reg <= SDWP_IDLE;
            SDWP_WP_BUSY:
               if (busy_cnt_reg == 8'(WP_BUSY_CYC))
                  state_reg <= SDWP_IDLE;
            SDWP_WP_SEND:
               state_reg <= SDWP_IDLE;
            default:
               state_reg <= SDWP_IDLE;
         endcase
      end
   end

   // Response flags, one cycle after the command
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         resp_valid         <= 1'b0;
         resp_busy_type     <= 1'b0;
         resp_illegal       <= 1'b0;
         resp_blk_len_err   <= 1'b0;
         resp_erase_seq_err <= 1'b0;
      end
      else
      begin
         resp_valid         <= cmd_valid;
         resp_busy_type     <= cmd_valid && (cmd_index == CMD_ERASE || cmd_index == CMD_WP_SET
                               || cmd_index == CMD_WP_CLR);
         resp_illegal       <= cmd_valid && (!cmd_take
                               || (cmd_index == CMD_PROG_ID && id_done_reg)
                               || cmd_index == CMD_RSV_A || cmd_index == CMD_RSV_B
                               || (is_wp_cmd && (high_cap || !ctrl_reg[CTRL_WP_FEAT])));
         resp_blk_len_err   <= cmd_take && cmd_index == CMD_SET_BLEN && !high_cap
                               && ((cmd_arg > DEF_BLOCK_LEN)
                               || (!ctrl_reg[CTRL_PARTIAL] && cmd_arg != DEF_BLOCK_LEN));
         resp_erase_seq_err <= cmd_take && cmd_index == CMD_ERASE
                               && !(er_start_ok_reg && er_end_ok_reg);
      end
   end

   // Block length, fixed on high capacity cards
   always_ff @(posedge mclk)
   begin
      if (rst)
         blk_len_reg <= DEF_BLOCK_LEN;
      else if (cmd_take && cmd_index == CMD_SET_BLEN && !high_cap && cmd_arg <= DEF_BLOCK_LEN
               && (ctrl_reg[CTRL_PARTIAL] || cmd_arg == DEF_BLOCK_LEN))
         blk_len_reg <= cmd_arg;
   end

   // Multiple block write runs until stop
   always_ff @(posedge mclk)
   begin
      if (rst)
         wr_multi_active <= 1'b0;
      else if (cmd_valid && cmd_index == CMD_STOP)
         wr_multi_active <= 1'b0;
      else if (cmd_take && cmd_index == CMD_WR_MULTI)
         wr_multi_active <= 1'b1;
   end

   // Erase range capture, valid flags cleared once an erase is done
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         er_start_reg    <= 32'h0;
         er_end_reg      <= 32'h0;
         er_start_ok_reg <= 1'b0;
         er_end_ok_reg   <= 1'b0;
         erase_groups    <= 1'b0;
      end
      else if (state_reg == SDWP_ERASE && erase_ack)
      begin
         er_start_ok_reg <= 1'b0;
         er_end_ok_reg   <= 1'b0;
      end
      else if (cmd_take && !mmc_mode && cmd_index == CMD_ER_START)
      begin
         er_start_reg    <= to_bytes(cmd_arg, high_cap);
         er_start_ok_reg <= 1'b1;
         erase_groups    <= 1'b0;
      end
      else if (cmd_take && !mmc_mode && cmd_index == CMD_ER_END)
      begin
         er_end_reg    <= to_bytes(cmd_arg, high_cap);
         er_end_ok_reg <= 1'b1;
      end
      else if (cmd_take && mmc_mode && cmd_index == CMD_GRP_START)
      begin
         er_start_reg    <= cmd_arg;
         er_start_ok_reg <= 1'b1;
         erase_groups    <= 1'b1;
      end
      else if (cmd_take && mmc_mode && cmd_index == CMD_GRP_END)
      begin
         er_end_reg    <= cmd_arg;
         er_end_ok_reg <= 1'b1;
      end
   end

   // Erase request to the storage array
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         erase_req   <= 1'b0;
         erase_first <= 32'h0;
         erase_last  <= 32'h0;
      end
      else if (state_reg == SDWP_ERASE && erase_ack)
         erase_req <= 1'b0;
      else if (erase_go)
      begin
         erase_req   <= 1'b1;
         erase_first <= er_start_reg;
         erase_last  <= er_end_reg;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Card register programming

   // Identification and card data blocks
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         id_done_reg  <= 1'b0;
         word_cnt_reg <= 2'h0;
         for (int i = 0; i < 4; i++)
         begin
            id_reg[i]   <= 32'h0;
            spec_reg[i] <= SPEC_RESET[32*(3-i) +: 32];
         end
      end
      else if (blk_valid && (state_reg == SDWP_RX_ID || state_reg == SDWP_RX_SPEC))
      begin
         word_cnt_reg <= blk_last ? 2'h0 : word_cnt_reg + 2'h1;
         if (state_reg == SDWP_RX_ID)
         begin
            id_reg[word_cnt_reg] <= blk_word;
            if (blk_last)
               id_done_reg <= 1'b1;
         end
         else
            spec_reg[word_cnt_reg] <= merge(spec_reg[word_cnt_reg], blk_word, word_cnt_reg);
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Write protection

   // Map update strobes and query window
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         set_bit_reg  <= 1'b0;
         clr_bit_reg  <= 1'b0;
         grp_idx_reg  <= 32'h0;
         busy_cnt_reg <= 8'h0;
      end
      else
      begin
         set_bit_reg <= 1'b0;
         clr_bit_reg <= 1'b0;
         if (cmd_take && is_wp_cmd && !high_cap && ctrl_reg[CTRL_WP_FEAT])
         begin
            grp_idx_reg  <= grp_of(cmd_arg, ctrl_reg[CTRL_GSH_LSB +: CTRL_GSH_W]);
            set_bit_reg  <= (cmd_index == CMD_WP_SET);
            clr_bit_reg  <= (cmd_index == CMD_WP_CLR);
            busy_cnt_reg <= 8'h0;
         end
         else if (state_reg == SDWP_WP_BUSY)
            busy_cnt_reg <= busy_cnt_reg + 8'h1;
      end
   end

   // Query answer word
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         wp_tx_valid <= 1'b0;
         wp_tx_word  <= 32'h0;
      end
      else
      begin
         wp_tx_valid <= (state_reg == SDWP_WP_SEND);
         if (state_reg == SDWP_WP_SEND)
            wp_tx_word <= wp_bus.rd_bits;
      end
   end

   // Busy on the data line while erasing or updating protection
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         dat0_out <= 1'b1;
         dat0_oe  <= 1'b0;
      end
      else
      begin
         dat0_out <= 1'b0;
         dat0_oe  <= erase_go || (state_reg == SDWP_ERASE && !erase_ack)
                     || (state_reg == SDWP_WP_BUSY && busy_cnt_reg != 8'(WP_BUSY_CYC));
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // APB slave, one wait state per access

   assign apb_access = psel && penable && !pready;

   // Read decode
   always_comb
   begin
      rd_next = 32'h0;
      rd_hit  = 1'b1;
      case (paddr)
         OFS_CTRL:     rd_next = ctrl_reg;
         OFS_STATUS:   rd_next = {24'h0, blk_len_err_reg, last_illegal_reg, wr_multi_active,
                                  er_end_ok_reg, er_start_ok_reg, dat0_oe, erase_req, id_done_reg};
         OFS_BLKLEN:   rd_next = blk_len_reg;
         OFS_ER_START: rd_next = er_start_reg;
         OFS_ER_END:   rd_next = er_end_reg;
         default:
         begin
            if (paddr[7:4] == OFS_ID_BASE[7:4] && paddr[1:0] == 2'h0)
               rd_next = id_reg[paddr[3:2]];
            else if (paddr[7:4] == OFS_SPEC_BASE[7:4] && paddr[1:0] == 2'h0)
               rd_next = spec_reg[paddr[3:2]];
            else
               rd_hit = 1'b0;
         end
      endcase
   end

   // Bus answer
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0;
      end
      else
      begin
         pready  <= apb_access;
         pslverr <= apb_access && !rd_hit;
         prdata  <= (apb_access && !pwrite && rd_hit) ? rd_next : 32'h0;
      end
   end

   // Control register, the only writable one
   always_ff @(posedge mclk)
   begin
      if (rst)
         ctrl_reg <= CTRL_RESET;
      else if (psel && penable && pready && pwrite && paddr == OFS_CTRL)
         ctrl_reg <= {24'h0, pwdata[7:4], 1'b0, pwdata[2:0]};
   end

   // Sticky status of the last command, replaced at the next one
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         last_illegal_reg <= 1'b0;
         blk_len_err_reg  <= 1'b0;
      end
      else if (resp_valid)
      begin
         last_illegal_reg <= resp_illegal;
         blk_len_err_reg  <= resp_blk_len_err;
      end
   end

endmodule

// ==== verilog/sdwp_pkg.sv ====
// Shared constants for the card write, erase and protect command unit
package sdwp_pkg;

   // Command indices handled or refused by this unit
   localparam logic [5:0] CMD_STOP      = 6'h0C;
   localparam logic [5:0] CMD_SET_BLEN  = 6'h10;
   localparam logic [5:0] CMD_WR_SINGLE = 6'h18;
   localparam logic [5:0] CMD_WR_MULTI  = 6'h19;
   localparam logic [5:0] CMD_PROG_ID   = 6'h1A;
   localparam logic [5:0] CMD_PROG_SPEC = 6'h1B;
   localparam logic [5:0] CMD_WP_SET    = 6'h1C;
   localparam logic [5:0] CMD_WP_CLR    = 6'h1D;
   localparam logic [5:0] CMD_WP_QUERY  = 6'h1E;
   localparam logic [5:0] CMD_ER_START  = 6'h20;
   localparam logic [5:0] CMD_ER_END    = 6'h21;
   localparam logic [5:0] CMD_RSV_A     = 6'h22;
   localparam logic [5:0] CMD_GRP_START = 6'h23;
   localparam logic [5:0] CMD_GRP_END   = 6'h24;
   localparam logic [5:0] CMD_RSV_B     = 6'h25;
   localparam logic [5:0] CMD_ERASE     = 6'h26;

   // Block geometry
   localparam logic [31:0] DEF_BLOCK_LEN = 32'h0000_0200;
   localparam int          BLOCK_SHIFT   = 9;

   // Register byte offsets on APB
   localparam logic [7:0] OFS_CTRL     = 8'h00;
   localparam logic [7:0] OFS_STATUS   = 8'h04;
   localparam logic [7:0] OFS_BLKLEN   = 8'h08;
   localparam logic [7:0] OFS_ER_START = 8'h0C;
   localparam logic [7:0] OFS_ER_END   = 8'h10;
   localparam logic [7:0] OFS_ID_BASE  = 8'h20;
   localparam logic [7:0] OFS_SPEC_BASE = 8'h30;

   // Control register fields
   localparam int CTRL_WP_FEAT   = 0;
   localparam int CTRL_PARTIAL   = 1;
   localparam int CTRL_MISALIGN  = 2;
   localparam int CTRL_GSH_LSB   = 4;
   localparam int CTRL_GSH_W     = 4;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0001;

   // Card data register: reset content and programmable bit mask
   localparam logic [127:0] SPEC_RESET = 128'h0026_0032_5F59_0000_0000_0000_0000_0000;
   localparam logic [127:0] SPEC_PMASK = 128'h0000_0000_0000_0000_0000_0000_0000_FFFE;

   // Busy time after a protection update
   localparam int WP_BUSY_NS  = 40;
   localparam int CLK_NS      = 5;
   localparam int WP_BUSY_CYC = (WP_BUSY_NS + CLK_NS - 1) / CLK_NS;

   // Command unit states
   typedef enum logic [2:0] {
      SDWP_IDLE, SDWP_RX_ID, SDWP_RX_SPEC, SDWP_ERASE, SDWP_WP_BUSY, SDWP_WP_SEND
   } sdwp_state_t;

endpackage

// ==== verilog/sdwp_wp_if.sv ====
// Carrier between the command unit and the protection bit map
`timescale 1ns/1ps
interface sdwp_wp_if #(parameter int GROUPS = 64);
   logic        set_bit;
   logic        clr_bit;
   logic [31:0] grp_idx;
   logic [31:0] rd_base;
   logic [31:0] rd_bits;

   modport ctrl (output set_bit, output clr_bit, output grp_idx, output rd_base,
                 input rd_bits);
   modport map  (input set_bit, input clr_bit, input grp_idx, input rd_base,
                 output rd_bits);
endinterface

// ==== verilog/sdwp_wp_map.sv ====
// Write protection bit map, one bit per protection group
`timescale 1ns/1ps
module sdwp_wp_map
   import sdwp_pkg::*;
#(
   parameter int GROUPS = 64
)(
   input  wire logic mclk,
   input  wire logic rst,
   sdwp_wp_if.map    wp
);

   logic [GROUPS-1:0] map_reg;

   // Window of 32 bits starting at a group, zero beyond the map
   function automatic logic [31:0] window(input logic [GROUPS-1:0] m, input logic [31:0] b);
      logic [31:0] r;
      r = 32'h0;
      for (int i = 0; i < 32; i++)
      begin
         if ((b + 32'(i)) < 32'(GROUPS))
            r[i] = m[b + 32'(i)];
      end
      return r;
   endfunction

   // Set and clear of the addressed group, out of range ignored
   always_ff @(posedge mclk)
   begin
      if (rst)
         map_reg <= '0;
      else if (wp.grp_idx < 32'(GROUPS))
      begin
         if (wp.set_bit)
            map_reg[wp.grp_idx] <= 1'b1;
         else if (wp.clr_bit)
            map_reg[wp.grp_idx] <= 1'b0;
      end
   end

   assign wp.rd_bits = window(map_reg, wp.rd_base);

endmodule

// ==== sim/sdwp_cmd_unit_sva.sv ====
// Port checker for the write, erase and protect command unit
`timescale 1ns/1ps
module sdwp_cmd_unit_sva
   import sdwp_pkg::*;
#(
   parameter int WP_GROUPS = 64
)(
   input wire logic       mclk,
   input wire logic       rst,
   input wire logic       high_cap,
   input wire logic       cmd_valid,
   input wire logic [5:0] cmd_index,
   input wire logic       resp_valid,
   input wire logic       resp_busy_type,
   input wire logic       resp_illegal,
   input wire logic       erase_req,
   input wire logic       erase_ack,
   input wire logic       wp_tx_valid,
   input wire logic       dat0_oe
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);

   ////////////////////////////////////////////////////////////////////////////////
   // Response timing and refusals
   a_resp_one_cycle: assert property (cmd_valid |=> resp_valid)
      else $error("response missing");
   a_erase_busy_kind: assert property (cmd_valid && cmd_index == CMD_ERASE && !dat0_oe
      |=> resp_busy_type) else $error("erase not busy kind");
   a_reserved_refused: assert property (cmd_valid && (cmd_index == CMD_RSV_A
      || cmd_index == CMD_RSV_B) |=> resp_illegal) else $error("reserved index accepted");
   a_hc_prot_refused: assert property (cmd_valid && high_cap && (cmd_index == CMD_WP_SET
      || cmd_index == CMD_WP_CLR || cmd_index == CMD_WP_QUERY) |=> resp_illegal)
      else $error("protect taken on high capacity");

   ////////////////////////////////////////////////////////////////////////////////
   // Busy line and erase handshake
   a_erase_line_busy: assert property (erase_req |-> dat0_oe)
      else $error("erase without busy line");
   a_erase_release: assert property (erase_req && erase_ack |=> !erase_req && !dat0_oe)
      else $error("erase not released");
   a_prot_busy_len: assert property ($rose(dat0_oe) && !erase_req
      |-> dat0_oe [*8] ##1 !dat0_oe) else $error("protect busy length wrong");
   a_query_sends: assert property (cmd_valid && cmd_index == CMD_WP_QUERY && !high_cap
      && !dat0_oe ##1 !resp_illegal |=> wp_tx_valid) else $error("query answer missing");
   a_tx_after_resp: assert property (wp_tx_valid |-> $past(resp_valid))
      else $error("word without a query");
endmodule

// ==== sim/sdwp_host_model.sv ====
// Host controller model issuing commands and data blocks to the card
`timescale 1ns/1ps
module sdwp_host_model
   import sdwp_pkg::*;
(
   input  wire logic mclk,
   output logic        cmd_valid,
   output logic [5:0]  cmd_index,
   output logic [31:0] cmd_arg,
   output logic        blk_valid,
   output logic [31:0] blk_word,
   output logic        blk_last
);
   // Idle bus at time zero
   initial
   begin
      {cmd_valid, cmd_index, cmd_arg, blk_valid, blk_word, blk_last} = '0;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // One command pulse, stale fields scrambled after it
   task automatic send(input logic [5:0] idx, input logic [31:0] arg);
      @(posedge mclk);
      cmd_valid <= 1'b1;
      cmd_index <= idx;
      cmd_arg   <= arg;
      @(posedge mclk);
      cmd_valid <= 1'b0;
      cmd_index <= ~idx;
      cmd_arg   <= ~arg;
   endtask

   // One block of four words, most significant first, kept inside a block
   task automatic blk(input logic [127:0] b);
      for (int i = 0; i < 4; i++)
      begin
         @(posedge mclk);
         blk_valid <= 1'b1;
         blk_word  <= b[127 - 32 * i -: 32];
         blk_last  <= (i == 3);
      end
      @(posedge mclk);
      blk_valid <= 1'b0;
      blk_last  <= 1'b0;
      blk_word  <= ~blk_word;
   endtask
endmodule

// ==== sim/sdwp_cmd_unit_test.sv ====
// Self-checking bench for the write, erase and protect command unit
`timescale 1ns/1ps
module sdwp_cmd_unit_test
   import sdwp_pkg::*;
;
   logic         mclk, rst, psel, penable, pwrite, high_cap, mmc_mode, erase_ack, err;
   logic [7:0]   paddr;
   logic [31:0]  pwdata, prdata, erase_first, erase_last, wp_tx_word, cmd_arg, blk_word;
   logic [31:0]  seed, rd, a, b;
   logic [127:0] w;
   logic [5:0]   cmd_index;
   logic         pready, pslverr, cmd_valid, blk_valid, blk_last, resp_valid, resp_busy_type;
   logic         resp_illegal, resp_blk_len_err, resp_erase_seq_err, erase_req, erase_groups;
   logic         wp_tx_valid, wr_multi_active, dat0_out, dat0_oe;
   int           mismatches, check_count, cycles;

   sdwp_cmd_unit u_sdwp_cmd_unit (.mclk(mclk), .rst(rst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .high_cap(high_cap), .mmc_mode(mmc_mode), .cmd_valid(cmd_valid),
      .cmd_index(cmd_index), .cmd_arg(cmd_arg), .blk_valid(blk_valid), .blk_word(blk_word),
      .blk_last(blk_last), .erase_ack(erase_ack), .resp_valid(resp_valid),
      .resp_busy_type(resp_busy_type), .resp_illegal(resp_illegal),
      .resp_blk_len_err(resp_blk_len_err), .resp_erase_seq_err(resp_erase_seq_err),
      .erase_req(erase_req), .erase_first(erase_first), .erase_last(erase_last),
      .erase_groups(erase_groups), .wp_tx_valid(wp_tx_valid), .wp_tx_word(wp_tx_word),
      .wr_multi_active(wr_multi_active), .dat0_out(dat0_out), .dat0_oe(dat0_oe));
   sdwp_host_model u_sdwp_host_model (.mclk(mclk), .cmd_valid(cmd_valid),
      .cmd_index(cmd_index), .cmd_arg(cmd_arg), .blk_valid(blk_valid), .blk_word(blk_word),
      .blk_last(blk_last));

   ////////////////////////////////////////////////////////////////////////////////
   // Helpers
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   function automatic logic [31:0] spec_exp(input int i, input logic [127:0] d);
      logic [127:0] v;
      v = (SPEC_RESET & ~SPEC_PMASK) | (d & SPEC_PMASK);
      return v[127 - 32 * i -: 32];
   endfunction

   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp)
      begin
         mismatches++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // APB transfer, held until pready is seen at an edge
   task automatic apb(input logic wr, input logic [7:0] ad, input logic [31:0] d);
      @(posedge mclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= ad;
      pwdata  <= d;
      @(posedge mclk);
      penable <= 1'b1;
      do @(posedge mclk); while (pready !== 1'b1);
      rd  = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rdchk(input logic [7:0] ad, input logic [31:0] e);
      apb(1'b0, ad, 32'h0);
      cmp(rd, e);
   endtask

   // Command with masked check of {valid, busy, illegal, length, sequence}
   task automatic issue(input logic [5:0] i, input logic [31:0] g, input logic [4:0] m,
                        input logic [4:0] e);
      u_sdwp_host_model.send(i, g);
      #1;
      cmp({27'h0, m & {resp_valid, resp_busy_type, resp_illegal, resp_blk_len_err,
          resp_erase_seq_err}}, {27'h0, e});
   endtask

   task automatic query(input logic [31:0] ad, input logic [2:0] e);
      issue(CMD_WP_QUERY, ad, 5'h1F, 5'h10);
      @(posedge mclk);
      #1;
      cmp({29'h0, wp_tx_valid, wp_tx_word[1:0]}, {29'h0, e});
   endtask

   task automatic idle();
      repeat (2) @(posedge mclk);
      while (dat0_oe !== 1'b0) @(posedge mclk);
      repeat (2) @(posedge mclk);
   endtask

   task automatic ack();
      @(posedge mclk);
      erase_ack <= 1'b1;
      @(posedge mclk);
      erase_ack <= 1'b0;
      idle();
   endtask

   task automatic conclude();
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // Clock and hang guard
   initial
   begin
      mclk = 1'b0;
      forever #2.5 mclk = ~mclk;
   end

   always @(posedge mclk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         mismatches++;
         conclude();
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial
   begin
      seed = 32'h4B97;
      {mismatches, check_count, cycles} = '0;
      {psel, penable, pwrite, high_cap, mmc_mode, erase_ack, paddr, pwdata} = '0;
      rst = 1'b1;
      repeat (3) @(posedge mclk);
      rst <= 1'b0;
      rdchk(OFS_CTRL, CTRL_RESET);
      rdchk(OFS_BLKLEN, DEF_BLOCK_LEN);
      rdchk(8'h14, 32'h0);
      cmp({31'h0, err}, 32'h1);
      $display("reset test done");
      for (int hc = 0; hc < 3; hc++)
      begin
         high_cap <= (hc == 1);
         mmc_mode <= (hc == 2);
         a = rnd() & 32'h003F_FFFF;
         b = a + (rnd() & 32'hFFFF);
         issue(hc == 2 ? CMD_GRP_START : CMD_ER_START, a, 5'h1F, 5'h10);
         issue(hc == 2 ? CMD_GRP_END : CMD_ER_END, b, 5'h1F, 5'h10);
         issue(CMD_ERASE, rnd(), 5'h1F, 5'h18);
         cmp({29'h0, erase_req, dat0_oe, erase_groups}, {29'h0, 2'b11, hc == 2});
         cmp(erase_first, hc == 1 ? a << BLOCK_SHIFT : a);
         cmp(erase_last, hc == 1 ? b << BLOCK_SHIFT : b);
         ack();
         issue(CMD_ERASE, 32'h0, 5'h11, 5'h11);
         ack();
      end
      {high_cap, mmc_mode} <= 2'b00;
      issue(CMD_RSV_A, rnd(), 5'h15, 5'h14);
      issue(CMD_RSV_B, rnd(), 5'h15, 5'h14);
      $display("erase test done");
      apb(1'b1, OFS_CTRL, 32'h0000_0011);
      a = ((rnd() % 50) + 2) << 10;
      issue(CMD_WP_SET, a | (rnd() & 32'h3FF), 5'h1F, 5'h18);
      idle();
      query(a - 32'h400, 3'b110);
      query(a, 3'b101);
      high_cap <= 1'b1;
      issue(CMD_WP_CLR, a, 5'h15, 5'h14);
      issue(CMD_WP_SET, a + 32'h400, 5'h15, 5'h14);
      high_cap <= 1'b0;
      query(a, 3'b101);
      issue(CMD_WP_CLR, a, 5'h1F, 5'h18);
      idle();
      query(a, 3'b100);
      apb(1'b1, OFS_CTRL, 32'h0000_0010);
      issue(CMD_WP_SET, a, 5'h15, 5'h14);
      $display("protect test done");
      for (int k = 0; k < 2; k++)
      begin
         w = {rnd(), rnd(), rnd(), rnd()};
         issue(k ? CMD_PROG_SPEC : CMD_PROG_ID, 32'h0, 5'h1F, 5'h10);
         u_sdwp_host_model.blk(w);
         idle();
         for (int i = 0; i < 4; i++)
            rdchk((k ? OFS_SPEC_BASE : OFS_ID_BASE) + 8'(4 * i),
                  k ? spec_exp(i, w) : w[127 - 32 * i -: 32]);
      end
      issue(CMD_PROG_ID, 32'h0, 5'h15, 5'h14);
      $display("program test done");
      issue(CMD_SET_BLEN, 32'h400, 5'h13, 5'h12);
      issue(CMD_SET_BLEN, 32'h100, 5'h13, 5'h12);
      rdchk(OFS_BLKLEN, DEF_BLOCK_LEN);
      apb(1'b1, OFS_CTRL, 32'h0000_0003);
      issue(CMD_SET_BLEN, 32'h100, 5'h13, 5'h10);
      rdchk(OFS_BLKLEN, 32'h100);
      issue(CMD_WR_MULTI, rnd() & 32'hFFFF_FE00, 5'h1F, 5'h10);
      u_sdwp_host_model.blk({rnd(), rnd(), rnd(), rnd()});
      u_sdwp_host_model.blk({rnd(), rnd(), rnd(), rnd()});
      cmp({30'h0, wr_multi_active, dat0_out}, 32'h2);
      issue(CMD_STOP, 32'h0, 5'h10, 5'h10);
      cmp({31'h0, wr_multi_active}, 32'h0);
      $display("length test done");
      conclude();
   end
endmodule

bind sdwp_cmd_unit sdwp_cmd_unit_sva #(.WP_GROUPS(WP_GROUPS)) u_sdwp_cmd_unit_sva (
   .mclk(mclk), .rst(rst), .high_cap(high_cap), .cmd_valid(cmd_valid),
   .cmd_index(cmd_index), .resp_valid(resp_valid), .resp_busy_type(resp_busy_type),
   .resp_illegal(resp_illegal), .erase_req(erase_req), .erase_ack(erase_ack),
   .wp_tx_valid(wp_tx_valid), .dat0_oe(dat0_oe));
